// >>> design/iu_special_regs.svh
`ifndef IU_SPECIAL_REGS_SVH
`define IU_SPECIAL_REGS_SVH

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TBA_MSB 31
`define TBA_LSB 12
`define TRAP_CODE_MSB 11
`define TRAP_CODE_LSB 4
`define TBR_RSVD_MSB 3
`define TBR_RSVD_LSB 0

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define CUR_ADDR_RESET 32'h0000_0000
`define NEXT_ADDR_RESET 32'h0000_0004
`define INSTR_STEP 32'h0000_0004
`define TBR_RSVD_VALUE 4'h0
`define RESET_TRAP_ADDR 32'h0000_0000

`endif

// >>> design/iu_special_pkg.sv
package iu_special_pkg;

  // Special-register operation issued by the pipeline
  typedef enum logic [2:0] {
    op_none = 3'b000,
    read_hi_word_op = 3'b001,
    write_hi_word_op = 3'b010,
    read_trap_base_op = 3'b011,
    write_trap_base_op = 3'b100,
    multiply_op = 3'b101,
    multiply_step_op = 3'b110,
    divide_op = 3'b111
  } special_op_t;

  typedef logic [31:0] word_t;
  typedef logic [7:0] trap_code_t;

endpackage

// >>> design/tmr_word.sv
// ----------------------------------------------------------------
// Triple-redundant word with majority vote
// ----------------------------------------------------------------
module tmr_word #(
  parameter int WIDTH = 32
) (
  // Clock
  input wire logic clk_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read side
  output logic [WIDTH-1:0] voted_out,
  output logic mismatch_out
);

  // No reset on purpose: the copies power up to whatever they hold and
  // the vote still yields a stable, readable value.
  logic [WIDTH-1:0] copy_a;
  logic [WIDTH-1:0] copy_b;
  logic [WIDTH-1:0] copy_c;

  function automatic logic [WIDTH-1:0] vote(input logic [WIDTH-1:0] a,
                                            input logic [WIDTH-1:0] b,
                                            input logic [WIDTH-1:0] c);
    vote = (a & b) | (a & c) | (b & c);
  endfunction

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      copy_a <= wr_data_in;
      copy_b <= wr_data_in;
      copy_c <= wr_data_in;
    end else begin
      // Scrub: an upset copy is repaired from the vote on the next edge
      copy_a <= vote(copy_a, copy_b, copy_c);
      copy_b <= vote(copy_a, copy_b, copy_c);
      copy_c <= vote(copy_a, copy_b, copy_c);
    end
  end

  assign voted_out = vote(copy_a, copy_b, copy_c);
  assign mismatch_out = (copy_a != copy_b) || (copy_b != copy_c);

endmodule

// >>> design/iu_special_state_regs.sv
`include "iu_special_regs.svh"

module iu_special_state_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Special-register operation from the pipeline
  input wire logic op_valid_in,
  input wire iu_special_pkg::special_op_t op_kind_in,
  input wire logic supervisor_in,
  input wire iu_special_pkg::word_t op_data_in,
  input wire iu_special_pkg::word_t product_hi_in,
  input wire logic multiply_step_bit_in,
  // Sequencing
  input wire logic advance_in,
  input wire iu_special_pkg::word_t branch_target_in,
  input wire logic branch_taken_in,
  input wire logic trap_in,
  input wire logic trap_is_reset_in,
  input wire iu_special_pkg::trap_code_t trap_code_in,
  input wire logic trap_return_in,
  input wire iu_special_pkg::word_t saved_cur_in,
  input wire iu_special_pkg::word_t saved_next_in,
  // Read result
  output logic rd_valid_out,
  output iu_special_pkg::word_t rd_data_out,
  output logic priv_trap_out,
  // Divide operand
  output iu_special_pkg::word_t dividend_hi_out,
  // Window save port
  output logic save_valid_out,
  output iu_special_pkg::word_t save_cur_out,
  output iu_special_pkg::word_t save_next_out,
  // Program counters and trap base
  output iu_special_pkg::word_t current_instr_addr_out,
  output iu_special_pkg::word_t next_instr_addr_out,
  output iu_special_pkg::word_t trap_base_out,
  output logic redundancy_error_out
);
  import iu_special_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic is_op(input logic valid, input special_op_t kind,
                                 input special_op_t want);
    is_op = valid && (kind == want);
  endfunction

  function automatic word_t trap_entry(input logic [19:0] base, input trap_code_t code);
    trap_entry = {base, code, `TBR_RSVD_VALUE};
  endfunction

  logic tbr_access;
  logic tbr_allowed;
  logic hi_write;
  logic tba_write;
  logic tt_write;

  assign tbr_access = is_op(op_valid_in, op_kind_in, read_trap_base_op) ||
                      is_op(op_valid_in, op_kind_in, write_trap_base_op);
  assign tbr_allowed = supervisor_in && !trap_in;
  assign hi_write = !trap_in && op_valid_in &&
                    (op_kind_in == write_hi_word_op || op_kind_in == multiply_op ||
                     op_kind_in == multiply_step_op);
  assign tba_write = is_op(op_valid_in, op_kind_in, write_trap_base_op) && tbr_allowed;
  assign tt_write = trap_in && !trap_is_reset_in;

  // ----------------------------------------------------------------
  // High-word register
  // ----------------------------------------------------------------
  word_t hi_word;
  word_t next_hi_word;
  logic hi_mismatch;

  always_comb begin
    next_hi_word = op_data_in;
    unique case (op_kind_in)
      multiply_op: next_hi_word = product_hi_in;
      // Each step shifts the low multiplier bit in from the top
      multiply_step_op: next_hi_word = {multiply_step_bit_in, hi_word[31:1]};
      default: next_hi_word = op_data_in;
    endcase
  end

  tmr_word #(.WIDTH(32)) hi_store (
    .clk_in(clk_in),
    .wr_en_in(hi_write),
    .wr_data_in(next_hi_word),
    .voted_out(hi_word),
    .mismatch_out(hi_mismatch)
  );

  assign dividend_hi_out = hi_word;

  // ----------------------------------------------------------------
  // Trap base register
  // ----------------------------------------------------------------
  logic [19:0] tba;
  trap_code_t trap_code;
  logic tba_mismatch;
  logic tt_mismatch;

  tmr_word #(.WIDTH(20)) tba_store (
    .clk_in(clk_in),
    .wr_en_in(tba_write),
    .wr_data_in(op_data_in[`TBA_MSB:`TBA_LSB]),
    .voted_out(tba),
    .mismatch_out(tba_mismatch)
  );

  // Software writes never reach this field; only a trap loads it
  tmr_word #(.WIDTH(8)) tt_store (
    .clk_in(clk_in),
    .wr_en_in(tt_write),
    .wr_data_in(trap_code_in),
    .voted_out(trap_code),
    .mismatch_out(tt_mismatch)
  );

  assign trap_base_out = trap_entry(tba, trap_code);
  assign redundancy_error_out = hi_mismatch || tba_mismatch || tt_mismatch;

  // ----------------------------------------------------------------
  // Program counters
  // ----------------------------------------------------------------
  word_t current_instr_addr;
  word_t next_instr_addr;
  word_t vector_addr;

  // The entry address uses the incoming code, not the stored one,
  // so the jump lands correctly in the same cycle the code is taken.
  assign vector_addr = trap_is_reset_in ? `RESET_TRAP_ADDR : trap_entry(tba, trap_code_in);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      current_instr_addr <= `CUR_ADDR_RESET;
      next_instr_addr <= `NEXT_ADDR_RESET;
    end else if (trap_in) begin
      current_instr_addr <= vector_addr;
      next_instr_addr <= vector_addr + `INSTR_STEP;
    end else if (trap_return_in) begin
      current_instr_addr <= saved_cur_in;
      next_instr_addr <= saved_next_in;
    end else if (advance_in) begin
      current_instr_addr <= next_instr_addr;
      next_instr_addr <= branch_taken_in ? branch_target_in
                                         : next_instr_addr + `INSTR_STEP;
    end
  end

  assign current_instr_addr_out = current_instr_addr;
  assign next_instr_addr_out = next_instr_addr;

  // ----------------------------------------------------------------
  // Window save port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      save_valid_out <= 1'b0;
      save_cur_out <= 32'h0000_0000;
      save_next_out <= 32'h0000_0000;
    end else begin
      save_valid_out <= trap_in;
      if (trap_in) begin
        save_cur_out <= current_instr_addr;
        save_next_out <= next_instr_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read results and privilege check
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= 32'h0000_0000;
      priv_trap_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      priv_trap_out <= tbr_access && !supervisor_in && !trap_in;
      if (is_op(op_valid_in, op_kind_in, read_hi_word_op) && !trap_in) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= hi_word;
      end else if (is_op(op_valid_in, op_kind_in, read_trap_base_op) && tbr_allowed) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= trap_entry(tba, trap_code);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence user_tbr_op;
    tbr_access && !supervisor_in && !trap_in;
  endsequence

  sequence trap_taken;
    trap_in && !trap_is_reset_in;
  endsequence

  chk_mul_hi_word: assert property (
    is_op(op_valid_in, op_kind_in, multiply_op) && !trap_in |=> hi_word == $past(product_hi_in))
    else $error("high word does not hold product upper word");

  chk_step_shift: assert property (
    is_op(op_valid_in, op_kind_in, multiply_step_op) && !trap_in
      |=> hi_word == {$past(multiply_step_bit_in), $past(hi_word[31:1])})
    else $error("multiply step did not shift high word");

  chk_divide_operand: assert property (
    is_op(op_valid_in, op_kind_in, divide_op) |=> dividend_hi_out == $past(hi_word))
    else $error("divide disturbed the high word operand");

  chk_user_hi_rw: assert property (
    is_op(op_valid_in, op_kind_in, write_hi_word_op) && !supervisor_in && !trap_in
      ##1 is_op(op_valid_in, op_kind_in, read_hi_word_op) && !trap_in
      |=> rd_valid_out && rd_data_out == $past(op_data_in, 2) && !priv_trap_out)
    else $error("user high word write then read failed");

  chk_hi_read_any: assert property (
    is_op(op_valid_in, op_kind_in, read_hi_word_op) && !trap_in
      |=> rd_valid_out && rd_data_out == $past(hi_word) && !priv_trap_out)
    else $error("high word read not answered");

  chk_tba_write: assert property (
    tba_write |=> trap_base_out[`TBA_MSB:`TBA_LSB] == $past(op_data_in[`TBA_MSB:`TBA_LSB]))
    else $error("trap base field not written");

  chk_trap_code_load: assert property (
    trap_taken |=> trap_base_out[`TRAP_CODE_MSB:`TRAP_CODE_LSB] == $past(trap_code_in))
    else $error("trap code not loaded on trap");

  chk_trap_code_hold: assert property (
    !(trap_in && !trap_is_reset_in) |=> $stable(trap_code))
    else $error("trap code changed without trap");

  chk_user_tbr_trap: assert property (
    user_tbr_op |=> priv_trap_out && !rd_valid_out && $stable(tba))
    else $error("user trap base access not refused");

  chk_advance: assert property (
    advance_in && !trap_in && !trap_return_in
      |=> current_instr_addr == $past(next_instr_addr))
    else $error("current address did not advance");

  chk_trap_save: assert property (
    trap_in |=> save_valid_out && save_cur_out == $past(current_instr_addr)
                && save_next_out == $past(next_instr_addr))
    else $error("trap did not save program counters");

  chk_trap_return: assert property (
    trap_return_in && !trap_in |=> current_instr_addr == $past(saved_cur_in)
                                   && next_instr_addr == $past(saved_next_in))
    else $error("return did not restore program counters");

  chk_sequential_next: assert property (
    advance_in && !trap_in && !trap_return_in && !branch_taken_in
      |=> next_instr_addr == $past(next_instr_addr) + `INSTR_STEP)
    else $error("next address not one step ahead");

  chk_trap_vector: assert property (
    trap_taken |=> current_instr_addr == {$past(tba), $past(trap_code_in), `TBR_RSVD_VALUE}
                   ##1 trap_code == $past(trap_code_in, 2) || $past(trap_in))
    else $error("trap entry address wrong");

  chk_reserved_zero: assert property (
    is_op(op_valid_in, op_kind_in, read_trap_base_op) && tbr_allowed
      |=> rd_data_out[`TBR_RSVD_MSB:`TBR_RSVD_LSB] == `TBR_RSVD_VALUE)
    else $error("trap base reserved bits not zero");

  chk_super_tbr_read: assert property (
    is_op(op_valid_in, op_kind_in, read_trap_base_op) && tbr_allowed
      |=> rd_valid_out && !priv_trap_out)
    else $error("supervisor trap base read refused");

  chk_reset_values: assert property (
    $rose(resetn_in) |-> current_instr_addr == `CUR_ADDR_RESET
                         && next_instr_addr == `NEXT_ADDR_RESET)
    else $error("reset values of program counters wrong");

  chk_vote_stable: assert property (
    !hi_write && !redundancy_error_out ##1 !hi_write |-> $stable(hi_word))
    else $error("redundant high word drifted");

endmodule

// >>> tb/window_store.sv
module window_store (
  // Clock
  input wire logic clk_in,
  // Save port from the block
  input wire logic save_valid_in,
  input wire iu_special_pkg::word_t save_cur_in,
  input wire iu_special_pkg::word_t save_next_in,
  // Local registers handed back on return
  output iu_special_pkg::word_t saved_cur_out,
  output iu_special_pkg::word_t saved_next_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import iu_special_pkg::*;

  // ----------------------------------------------------------------
  // Local registers of the trap window
  // ----------------------------------------------------------------
  // Junk until the first save, so a return without a save cannot pass
  word_t l1 = 32'h5a5a_a5a5;
  word_t l2 = 32'ha5a5_5a5a;

  always_ff @(posedge clk_in) begin
    if (save_valid_in) begin
      l1 <= save_cur_in;
      l2 <= save_next_in;
    end
  end

  assign saved_cur_out = l1;
  assign saved_next_out = l2;
endmodule

// >>> tb/iu_special_state_regs_tb_top.sv
module iu_special_state_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import iu_special_pkg::*;

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic op_valid_in = 1'b0;
  special_op_t op_kind_in = op_none;
  logic supervisor_in = 1'b0;
  word_t op_data_in = 32'h0;
  word_t product_hi_in = 32'h0;
  logic multiply_step_bit_in = 1'b0;
  logic advance_in = 1'b0;
  word_t branch_target_in = 32'h0;
  logic branch_taken_in = 1'b0;
  logic trap_in = 1'b0;
  logic trap_is_reset_in = 1'b0;
  trap_code_t trap_code_in = 8'h0;
  logic trap_return_in = 1'b0;
  word_t saved_cur, saved_next, rd_data, dividend_hi, save_cur, save_next, cur, nxt, tbase;
  logic rd_valid, priv_trap, save_valid, red_err;
  int err_count = 0;
  int total_checks = 0;

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  iu_special_state_regs u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .op_valid_in(op_valid_in),
    .op_kind_in(op_kind_in), .supervisor_in(supervisor_in), .op_data_in(op_data_in),
    .product_hi_in(product_hi_in), .multiply_step_bit_in(multiply_step_bit_in),
    .advance_in(advance_in), .branch_target_in(branch_target_in),
    .branch_taken_in(branch_taken_in), .trap_in(trap_in), .trap_is_reset_in(trap_is_reset_in),
    .trap_code_in(trap_code_in), .trap_return_in(trap_return_in),
    .saved_cur_in(saved_cur), .saved_next_in(saved_next), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .priv_trap_out(priv_trap), .dividend_hi_out(dividend_hi),
    .save_valid_out(save_valid), .save_cur_out(save_cur), .save_next_out(save_next),
    .current_instr_addr_out(cur), .next_instr_addr_out(nxt), .trap_base_out(tbase),
    .redundancy_error_out(red_err));

  window_store u_window (
    .clk_in(clk_in), .save_valid_in(save_valid), .save_cur_in(save_cur),
    .save_next_in(save_next), .saved_cur_out(saved_cur), .saved_next_out(saved_next));

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic drive(input special_op_t k, input word_t d, input logic s);
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_kind_in <= k;
    op_data_in <= d;
    supervisor_in <= s;
  endtask

  // Drops every request; the answer of the previous edge is then settled
  task automatic idle();
    @(posedge clk_in);
    op_valid_in <= 1'b0;
    op_kind_in <= op_none;
    advance_in <= 1'b0;
    branch_taken_in <= 1'b0;
    trap_in <= 1'b0;
    trap_is_reset_in <= 1'b0;
    trap_return_in <= 1'b0;
    #1;
  endtask

  task automatic pulse_trap(input logic is_rst, input trap_code_t c);
    @(posedge clk_in);
    trap_in <= 1'b1;
    trap_is_reset_in <= is_rst;
    trap_code_in <= c;
    idle();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    `CHK(cur, 32'h0000_0000)
    `CHK(nxt, 32'h0000_0004)
  endtask

  task automatic hi_word_user();
    drive(write_hi_word_op, 32'h1234_5678, 1'b0);
    drive(read_hi_word_op, 32'h0, 1'b0);
    idle();
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, 32'h1234_5678)
    `CHK(dividend_hi, 32'h1234_5678)
  endtask

  task automatic multiply_paths();
    drive(multiply_op, 32'h0, 1'b0);
    product_hi_in <= 32'h0000_00f0;
    idle();
    `CHK(dividend_hi, 32'h0000_00f0)
    drive(multiply_step_op, 32'h0, 1'b0);
    multiply_step_bit_in <= 1'b1;
    idle();
    `CHK(dividend_hi, 32'h8000_0078)
    drive(divide_op, 32'hffff_ffff, 1'b0);
    idle();
    `CHK(dividend_hi, 32'h8000_0078)
  endtask

  task automatic trap_base_access();
    drive(write_trap_base_op, 32'habcd_efff, 1'b1);
    drive(read_trap_base_op, 32'h0, 1'b1);
    idle();
    `CHK(rd_data[31:12], 20'habcde)
    `CHK(rd_data[3:0], 4'h0)
    drive(write_trap_base_op, 32'h1111_1000, 1'b0);
    drive(read_trap_base_op, 32'h0, 1'b0);
    @(posedge clk_in);
    #1;
    `CHK(priv_trap, 1'b1)
    `CHK(rd_valid, 1'b0)
    idle();
    `CHK(priv_trap, 1'b1)
    `CHK(tbase[31:12], 20'habcde)
  endtask

  task automatic counters_step();
    @(posedge clk_in);
    advance_in <= 1'b1;
    idle();
    `CHK({cur, nxt}, {32'h4, 32'h8})
    @(posedge clk_in);
    advance_in <= 1'b1;
    branch_taken_in <= 1'b1;
    branch_target_in <= 32'h0000_0100;
    idle();
    `CHK({cur, nxt}, {32'h8, 32'h100})
  endtask

  task automatic trap_and_return();
    pulse_trap(1'b0, 8'h2a);
    `CHK(save_valid, 1'b1)
    `CHK({save_cur, save_next}, {32'h8, 32'h100})
    `CHK({cur, nxt}, {32'habcd_e2a0, 32'habcd_e2a4})
    `CHK(tbase, 32'habcd_e2a0)
    @(posedge clk_in);
    trap_return_in <= 1'b1;
    idle();
    `CHK({cur, nxt}, {32'h8, 32'h100})
    pulse_trap(1'b1, 8'h55);
    `CHK({cur, nxt}, {32'h0, 32'h4})
    `CHK(tbase[11:4], 8'h2a)
    drive(write_trap_base_op, 32'h1357_9fff, 1'b1);
    drive(read_trap_base_op, 32'h0, 1'b1);
    idle();
    `CHK(rd_data, 32'h1357_92a0)
    `CHK(red_err, 1'b0)
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounds the whole run in case a driver stalls
  initial begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    idle();
    reset_values();
    hi_word_user();
    multiply_paths();
    trap_base_access();
    counters_step();
    trap_and_return();
    stop_test();
  end
endmodule
